// file: logic/mie_exec.sv
// What this block does
// - immediate-subtract puts immediate minus accumulator in accumulator; zero, digit carry, carry change.
// - after subtraction carry means no borrow; set on non-negative, cleared on underflow.
// - table read addresses program word {pointer low three bits, accumulator}; low byte to accumulator.
// - table read puts program word bits 13..8 into table-high-data bits 5..0.
// - load-timer-mode copies accumulator into timer0 mode; accumulator and flags untouched.
// - read-timer-mode copies timer0 mode into accumulator; mode and flags untouched.
// - register XOR with file register 0..127, only Z changes; d picks destination.
// - immediate XOR into accumulator, only the zero flag changes.
`timescale 1ns/1ps
`default_nettype none
module mie_exec (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // instruction stream
   input wire logic instr_valid_i,
   input wire logic [mie_pkg::INSTR_W-1:0] instr_i,
   output logic instr_ready_o,
   // program memory table port
   output logic rom_rd_o,
   output logic [mie_pkg::ROM_ADDR_W-1:0] rom_addr_o,
   input wire logic [mie_pkg::INSTR_W-1:0] rom_data_i,
   // core state view
   output logic [7:0] accumulator_o,
   output logic [mie_pkg::FLAG_W-1:0] status_o,
   output logic [7:0] timer0_mode_o,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o
);
   import mie_pkg::*;

   typedef struct packed {
      mie_state_t state;
      logic ready;
      logic rom_rd;
      logic [ROM_ADDR_W-1:0] rom_addr;
      logic [7:0] accumulator;
      logic [FLAG_W-1:0] status;
      logic [7:0] timer0_mode_reg;
      logic [THP_W-1:0] table_high_pointer;
      logic [THD_W-1:0] table_high_data;
      logic [FILE_DEPTH-1:0][7:0] file_reg;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } mie_regs_t;

   mie_regs_t r;
   mie_regs_t next_r;

   // file registers sit in a word window above the control registers
   function automatic logic is_file_addr(input logic [11:0] a);
      is_file_addr = (a[11:9] == FILE_WINDOW_SEL) && (a[1:0] == 2'h0);
   endfunction : is_file_addr

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = is_file_addr(a) || (a == OFS_ACCUMULATOR) || (a == OFS_STATUS) || (a == OFS_TIMER0_MODE)
         || (a == OFS_TABLE_HIGH_POINTER) || (a == OFS_TABLE_HIGH_DATA) || (a == OFS_EXEC_STATE);
   endfunction : is_mapped

   logic [7:0] opnd;
   logic [FILE_IDX_W-1:0] fidx;
   logic [8:0] sub_sum;
   logic [4:0] sub_low;
   logic [7:0] xor_val;
   logic take;

   always_comb begin
      opnd = instr_i[7:0];
      fidx = instr_i[FILE_IDX_W-1:0];
      sub_sum = {1'b0, opnd} + {1'b0, ~r.accumulator} + 9'h001;
      sub_low = {1'b0, opnd[3:0]} + {1'b0, ~r.accumulator[3:0]} + 5'h01;
      xor_val = r.accumulator ^ r.file_reg[fidx];
      take = instr_valid_i && r.ready;
   end

   always_comb begin
      next_r = r;
      next_r.rom_rd = 1'b0;
      case (r.state)
         MIE_ST_IDLE: begin
            next_r.ready = 1'b1;
            if (take) begin
               case (instr_i[OPC_MSB:OPC_LSB])
                  OP_SUB_ACC_FROM_IMMEDIATE: begin
                     next_r.accumulator = sub_sum[7:0];
                     next_r.status[FLAG_Z] = (sub_sum[7:0] == 8'h00);
                     next_r.status[FLAG_DIGIT_CARRY] = sub_low[4];
                     next_r.status[FLAG_C] = sub_sum[8];
                  end
                  OP_XOR_IMMEDIATE_INTO_ACC: begin
                     next_r.accumulator = r.accumulator ^ opnd;
                     next_r.status[FLAG_Z] = ((r.accumulator ^ opnd) == 8'h00);
                  end
                  OP_XOR_ACC_WITH_FILE_REG: begin
                     if (instr_i[DEST_BIT]) begin
                        next_r.file_reg[fidx] = xor_val;
                     end else begin
                        next_r.accumulator = xor_val;
                     end
                     next_r.status[FLAG_Z] = (xor_val == 8'h00);
                  end
                  OP_PROGRAM_TABLE_READ: begin
                     // second cycle waits for the program word
                     next_r.state = MIE_ST_TABLE;
                     next_r.ready = 1'b0;
                     next_r.rom_rd = 1'b1;
                     next_r.rom_addr = {r.table_high_pointer, r.accumulator};
                  end
                  OP_LOAD_TIMER0_MODE: begin
                     next_r.timer0_mode_reg = r.accumulator;
                  end
                  OP_READ_TIMER0_MODE: begin
                     next_r.accumulator = r.timer0_mode_reg;
                  end
                  default: begin
                     // unknown opcodes retire as no-ops
                     next_r.ready = 1'b1;
                  end
               endcase
            end
         end
         MIE_ST_TABLE: begin
            // memory answers combinationally while the read strobe stands
            next_r.accumulator = rom_data_i[7:0];
            next_r.table_high_data = rom_data_i[13:8];
            next_r.state = MIE_ST_IDLE;
            next_r.ready = 1'b1;
         end
         default: begin
            next_r.state = MIE_ST_IDLE;
            next_r.ready = 1'b1;
         end
      endcase

      // apb: answer one cycle after setup, no wait states
      next_r.pready = 1'b0;
      if (psel_i && !penable_i) begin
         next_r.pready = 1'b1;
         next_r.pslverr = !is_mapped(paddr_i);
         next_r.prdata = 32'h0000_0000;
         if (is_file_addr(paddr_i)) begin
            next_r.prdata = {24'h00_0000, r.file_reg[paddr_i[8:2]]};
         end else begin
            case (paddr_i)
               OFS_ACCUMULATOR: next_r.prdata = {24'h00_0000, r.accumulator};
               OFS_STATUS: next_r.prdata = {29'h0000_0000, r.status};
               OFS_TIMER0_MODE: next_r.prdata = {24'h00_0000, r.timer0_mode_reg};
               OFS_TABLE_HIGH_POINTER: next_r.prdata = {29'h0000_0000, r.table_high_pointer};
               OFS_TABLE_HIGH_DATA: next_r.prdata = {26'h000_0000, r.table_high_data};
               OFS_EXEC_STATE: next_r.prdata = {31'h0000_0000, r.state == MIE_ST_TABLE};
               default: next_r.prdata = 32'h0000_0000;
            endcase
         end
      end
      // software write lands last, so it overrides a same-cycle instruction result
      if (psel_i && penable_i && r.pready && pwrite_i && !r.pslverr) begin
         if (is_file_addr(paddr_i)) begin
            next_r.file_reg[paddr_i[8:2]] = pwdata_i[7:0];
         end else begin
            case (paddr_i)
               OFS_ACCUMULATOR: next_r.accumulator = pwdata_i[7:0];
               OFS_STATUS: next_r.status = pwdata_i[FLAG_W-1:0];
               OFS_TIMER0_MODE: next_r.timer0_mode_reg = pwdata_i[7:0];
               OFS_TABLE_HIGH_POINTER: next_r.table_high_pointer = pwdata_i[THP_W-1:0];
               OFS_TABLE_HIGH_DATA: next_r.table_high_data = pwdata_i[THD_W-1:0];
               default: next_r.status = next_r.status;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         r.state <= MIE_ST_IDLE;
         r.ready <= 1'b0;
         r.rom_rd <= 1'b0;
         r.rom_addr <= '0;
         r.accumulator <= RST_ACCUMULATOR;
         r.status <= RST_STATUS;
         r.timer0_mode_reg <= RST_TIMER0_MODE;
         r.table_high_pointer <= RST_TABLE_HIGH_POINTER;
         r.table_high_data <= RST_TABLE_HIGH_DATA;
         r.file_reg <= {FILE_DEPTH{RST_FILE}};
         r.pready <= 1'b0;
         r.prdata <= 32'h0000_0000;
         r.pslverr <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign instr_ready_o = r.ready;
   assign rom_rd_o = r.rom_rd;
   assign rom_addr_o = r.rom_addr;
   assign accumulator_o = r.accumulator;
   assign status_o = r.status;
   assign timer0_mode_o = r.timer0_mode_reg;
   assign pready_o = r.pready;
   assign prdata_o = r.prdata;
   assign pslverr_o = r.pslverr;
endmodule : mie_exec
`default_nettype wire

// file: shared/mie_pkg.sv
`default_nettype none
package mie_pkg;
   // instruction word layout: opcode in the top six bits, operand below
   localparam int INSTR_W = 14;
   localparam int OPC_MSB = 13;
   localparam int OPC_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam int ROM_ADDR_W = 11;
   localparam int FILE_IDX_W = 7;
   localparam int FILE_DEPTH = 128;
   localparam int THD_W = 6;
   localparam int THP_W = 3;

   // opcodes
   localparam logic [5:0] OP_SUB_ACC_FROM_IMMEDIATE = 6'h01;
   localparam logic [5:0] OP_XOR_IMMEDIATE_INTO_ACC = 6'h02;
   localparam logic [5:0] OP_XOR_ACC_WITH_FILE_REG = 6'h03;
   localparam logic [5:0] OP_PROGRAM_TABLE_READ = 6'h04;
   localparam logic [5:0] OP_LOAD_TIMER0_MODE = 6'h05;
   localparam logic [5:0] OP_READ_TIMER0_MODE = 6'h06;

   // status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_DIGIT_CARRY = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_W = 3;

   // register byte offsets
   localparam logic [11:0] OFS_ACCUMULATOR = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_TIMER0_MODE = 12'h008;
   localparam logic [11:0] OFS_TABLE_HIGH_POINTER = 12'h00c;
   localparam logic [11:0] OFS_TABLE_HIGH_DATA = 12'h010;
   localparam logic [11:0] OFS_EXEC_STATE = 12'h014;
   localparam logic [2:0] FILE_WINDOW_SEL = 3'h1;

   // reset values
   localparam logic [7:0] RST_ACCUMULATOR = 8'h00;
   localparam logic [2:0] RST_STATUS = 3'h0;
   localparam logic [7:0] RST_TIMER0_MODE = 8'h00;
   localparam logic [2:0] RST_TABLE_HIGH_POINTER = 3'h0;
   localparam logic [5:0] RST_TABLE_HIGH_DATA = 6'h00;
   localparam logic [7:0] RST_FILE = 8'h00;

   typedef enum logic [0:0] {
      MIE_ST_IDLE = 1'b0,
      MIE_ST_TABLE = 1'b1
   } mie_state_t;
endpackage : mie_pkg
`default_nettype wire

// file: test/mie_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mie_exec_chk (
   // core side
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic instr_valid_i,
   input wire logic [13:0] instr_i,
   input wire logic instr_ready_o,
   input wire logic rom_rd_o,
   input wire logic [10:0] rom_addr_o,
   input wire logic [13:0] rom_data_i,
   input wire logic [7:0] accumulator_o,
   input wire logic [2:0] status_o,
   input wire logic [7:0] timer0_mode_o,
   // apb
   input wire logic psel_i,
   input wire logic penable_i
);
   logic tk;
   logic [5:0] op;
   assign op = instr_i[13:8];
   // an apb write in the same edge wins, so leave those out
   assign tk = instr_valid_i && instr_ready_o && !(psel_i && penable_i);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_sub_result: assert property (tk && op == 6'h01 |=>
      accumulator_o == $past(instr_i[7:0]) - $past(accumulator_o) && status_o[2] == (accumulator_o == 8'h00))
      else $error("subtract result wrong");
   a_sub_carry: assert property (tk && op == 6'h01 |=>
      status_o[0] == ($past(instr_i[7:0]) >= $past(accumulator_o))) else $error("subtract carry wrong");
   a_tbl_addr: assert property (tk && op == 6'h04 |=>
      rom_rd_o && rom_addr_o[7:0] == $past(accumulator_o)) else $error("table address wrong");
   a_tbl_load: assert property (rom_rd_o && !(psel_i && penable_i) |=>
      accumulator_o == $past(rom_data_i[7:0])) else $error("table data not loaded");
   a_tbl_cycles: assert property (tk && op == 6'h04 |=> !instr_ready_o ##1 instr_ready_o)
      else $error("table cycle count wrong");
   a_ld_mode: assert property (tk && op == 6'h05 |=> timer0_mode_o == $past(accumulator_o)
      && $stable(accumulator_o) && $stable(status_o)) else $error("mode load wrong");
   a_rd_mode: assert property (tk && op == 6'h06 |=> accumulator_o == $past(timer0_mode_o)
      && $stable(timer0_mode_o) && $stable(status_o)) else $error("mode read wrong");
   a_xori_zero: assert property (tk && op == 6'h02 |=>
      accumulator_o == ($past(instr_i[7:0]) ^ $past(accumulator_o)) && $stable(status_o[1:0])
      && status_o[2] == (accumulator_o == 8'h00)) else $error("immediate xor wrong");
   a_xorf_flags: assert property (tk && op == 6'h03 && !instr_i[7] |=>
      $stable(status_o[1:0]) && status_o[2] == (accumulator_o == 8'h00)) else $error("file xor flags wrong");
endmodule : mie_exec_chk
bind mie_exec mie_exec_chk u_chk (.*);
`default_nettype wire

// file: test/mie_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mie_exec_tb;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [13:0] instr_i = 14'h0000, rom_data_i;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic instr_ready_o, rom_rd_o, pready_o, pslverr_o, err;
   logic [10:0] rom_addr_o;
   logic [7:0] accumulator_o, timer0_mode_o;
   logic [2:0] status_o;
   int bad_count, compares, cyc;
   mie_exec u_dut (.*);
   mie_rom_model u_rom (.rom_rd_i(rom_rd_o), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i));
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // a hang counts as a mismatch
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic ex(input logic [5:0] op, input logic [7:0] v);
      @(posedge ref_clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= {op, v};
      do @(posedge ref_clk_i); while (instr_ready_o !== 1'b1);
      instr_valid_i <= 1'b0;
      #1;
   endtask : ex
   // preset accumulator, run one instruction, compare the core state
   task automatic run(input logic [7:0] a, input logic [5:0] op, input logic [7:0] v, input logic [7:0] r,
                      input logic [2:0] st);
      apb(1'b1, 12'h000, {24'h0, a});
      ex(op, v);
      chk("acc", accumulator_o, r);
      chk("status", status_o, st);
   endtask : run
   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      apb(1'b0, 12'h7f0, 32'h0);
      chk("slverr", err, 1);
      chk("mode rst", timer0_mode_o, 0);
      run(8'h06, 6'h01, 8'h05, 8'hff, 3'b000);
      run(8'h05, 6'h01, 8'h06, 8'h01, 3'b011);
      run(8'h05, 6'h01, 8'h05, 8'h00, 3'b111);
      run(8'hf0, 6'h02, 8'ha5, 8'h55, 3'b011);
      run(8'h55, 6'h02, 8'h55, 8'h00, 3'b111);
      apb(1'b1, 12'h3fc, 32'ha5);
      run(8'hf0, 6'h03, 8'hff, 8'hf0, 3'b011);
      apb(1'b0, 12'h3fc, 32'h0);
      chk("file reg", rd, 32'h55);
      run(8'hf0, 6'h03, 8'h7f, 8'ha5, 3'b011);
      run(8'haa, 6'h05, 8'h00, 8'haa, 3'b011);
      chk("mode", timer0_mode_o, 8'haa);
      run(8'h11, 6'h06, 8'h00, 8'haa, 3'b011);
      apb(1'b1, 12'h00c, 32'h2);
      apb(1'b1, 12'h000, 32'h34);
      ex(6'h04, 8'h00);
      chk("wait ready", instr_ready_o, 0);
      chk("rom addr", rom_addr_o, 11'h234);
      chk("rom rd", rom_rd_o, 1);
      @(posedge ref_clk_i);
      #1;
      chk("table acc", accumulator_o, 8'h34 ^ 8'h5a);
      chk("ready", instr_ready_o, 1);
      apb(1'b0, 12'h010, 32'h0);
      chk("high data", rd, {26'h0, 3'b010, 3'b100});
      stop_test();
   end
endmodule : mie_exec_tb
`default_nettype wire

// file: test/mie_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module mie_rom_model (
   // fetch from the core
   input wire logic rom_rd_i,
   input wire logic [10:0] rom_addr_i,
   // word back
   output logic [13:0] rom_data_o
);
   logic [13:0] word;
   // address-derived content, so a wrong address cannot match
   assign word = {rom_addr_i[10:8], rom_addr_i[2:0], rom_addr_i[7:0] ^ 8'h5a};
   // outside a fetch the bus shows the inverse, never a stale word
   assign rom_data_o = rom_rd_i ? word : ~word;
endmodule : mie_rom_model
`default_nettype wire
